// file: hdl/acpc_pkg.sv
// package of constants and types for the conversion control and parallel port
package acpc_pkg;
  localparam int            DATA_W          = 12;
  localparam int            CHAN_W          = 3;
  localparam int            CONV_EDGES      = 13;
  localparam int            EDGE_CNT_W      = 4;
  localparam int            CLK_PERIOD_PS   = 4000;
  localparam int            TAIL_DELAY_PS   = 20000;
  localparam int            TAIL_CYCLES     = (TAIL_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int            TAIL_CNT_W      = 4;
  localparam int            FIFO_DEPTH      = 4;
  localparam logic [3:0]    CNT_ZERO        = 4'h0;
  localparam logic [3:0]    CNT_ONE         = 4'h1;
  localparam logic [1:0]    PWR_AUTO_SHUT   = 2'h2;
  localparam logic [1:0]    PWR_AUTO_STBY   = 2'h1;
  localparam logic [15:0]   CTRL_RESET      = 16'h0000;
  localparam int            PWR_LSB         = 0;
  localparam int            ZERO_DATA       = 0;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] code;
  } acpc_result_type;

  typedef struct packed {
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
  } acpc_strobe_type;
endpackage : acpc_pkg

// file: hdl/acpc_sync.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module acpc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // next values: first stage only feeds second
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // register stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule : acpc_sync

// file: hdl/acpc_fifo.sv
// result fifo with valid and ready on both sides
`timescale 1ns/10ps
module acpc_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  // handshake and pointer update
  always_comb begin
    in_ready   = (32'(count_ff) != DEPTH);                 // full at DEPTH entries
    out_valid  = (count_ff != '0);
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    nxt_wr_ptr = push ? ((32'(wr_ptr_ff) == DEPTH - 1) ? '0 : wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? ((32'(rd_ptr_ff) == DEPTH - 1) ? '0 : rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count  = count_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  // storage and pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  assign out_data = mem_ff[rd_ptr_ff];
endmodule : acpc_fifo

// file: hdl/acpc_ctrl.sv
// conversion control, busy, track-and-hold and parallel host port
`timescale 1ns/10ps
module acpc_ctrl
  import acpc_pkg::*;
#(
  parameter int DATA_W_P  = acpc_pkg::DATA_W,
  parameter int TAIL_P    = acpc_pkg::TAIL_CYCLES,
  parameter int DEPTH_P   = acpc_pkg::FIFO_DEPTH
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             master_clock_in,
  input  wire logic                             conversion_start_n,
  input  wire acpc_pkg::acpc_strobe_type        host_strobe,
  input  wire logic [acpc_pkg::DATA_W-1:0]      db_in,
  output logic [acpc_pkg::DATA_W-1:0]           db_out,
  output logic                                  db_oe,
  output logic                                  busy,
  output logic                                  hold,
  output logic                                  powered_up,
  output logic                                  sar_start,
  input  wire acpc_pkg::acpc_result_type        sar_result,
  output logic [acpc_pkg::DATA_W-1:0]           ctrl_word,
  output logic                                  ctrl_wr_pulse,
  output logic                                  result_overrun
);
  import acpc_pkg::*;

  typedef enum {ST_IDLE, ST_CONV, ST_TAIL, ST_LOAD} acpc_state_type;

  logic            mclk_s;
  logic            cvs_s;
  logic            cs_n_s;
  logic            rd_n_s;
  logic            wr_n_s;
  acpc_state_type  state_ff;
  acpc_state_type  nxt_state;
  logic            mclk_d_ff;
  logic            cvs_d_ff;
  logic            rd_act_d_ff;
  logic            wr_act_d_ff;
  logic [EDGE_CNT_W-1:0] edge_cnt_ff;
  logic [EDGE_CNT_W-1:0] nxt_edge_cnt;
  logic [TAIL_CNT_W-1:0] tail_cnt_ff;
  logic [TAIL_CNT_W-1:0] nxt_tail_cnt;
  logic            hold_ff;
  logic            nxt_hold;
  logic            busy_ff;
  logic            nxt_busy;
  logic            pwr_ff;
  logic            nxt_pwr;
  logic [DATA_W-1:0] out_reg_ff;
  logic [DATA_W-1:0] nxt_out_reg;
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] nxt_ctrl;
  logic            ovr_ff;
  logic            nxt_ovr;
  logic            mclk_rise;
  logic            cvs_fall;
  logic            cvs_rise;
  logic            rd_act;
  logic            wr_act;
  logic            rd_fall;
  logic            wr_rise;
  logic            fifo_in_valid;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic            fifo_out_ready;
  logic [DATA_W+CHAN_W-1:0] fifo_out_data;
  acpc_result_type fifo_head;
  // data pin synchroniser and edge history next values
  logic [DATA_W-1:0] db_meta_ff;
  logic [DATA_W-1:0] db_sync_ff;
  logic [DATA_W-1:0] nxt_db_meta;
  logic [DATA_W-1:0] nxt_db_sync;
  logic            nxt_mclk_d;
  logic            nxt_cvs_d;
  logic            nxt_rd_act_d;
  logic            nxt_wr_act_d;

  // all pin inputs pass two flip-flops before logic reads them
  // master clock level; only its rising edges pace the conversion
  acpc_sync #(.RST_VAL(1'b0)) u_sync_mclk (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (master_clock_in),
    .sync_out (mclk_s)
  );
  // conversion start idles high, so reset leaves no false edge
  acpc_sync #(.RST_VAL(1'b1)) u_sync_cvs (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (conversion_start_n),
    .sync_out (cvs_s)
  );
  // chip select, idles high
  acpc_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (host_strobe.cs_n),
    .sync_out (cs_n_s)
  );
  // read strobe, idles high
  acpc_sync #(.RST_VAL(1'b1)) u_sync_rd (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (host_strobe.rd_n),
    .sync_out (rd_n_s)
  );
  // write strobe, idles high
  acpc_sync #(.RST_VAL(1'b1)) u_sync_wr (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (host_strobe.wr_n),
    .sync_out (wr_n_s)
  );

  // results queue between converter core and host read port
  acpc_fifo #(.WIDTH(DATA_W + CHAN_W), .DEPTH(DEPTH_P)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (sar_result),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // edge detection on synchronised levels
  always_comb begin
    mclk_rise = mclk_s && !mclk_d_ff;
    cvs_fall  = !cvs_s && cvs_d_ff;
    cvs_rise  = cvs_s && !cvs_d_ff;
    rd_act    = !cs_n_s && !rd_n_s;
    wr_act    = !cs_n_s && !wr_n_s;
    rd_fall   = rd_act && !rd_act_d_ff;
    wr_rise   = !wr_act && wr_act_d_ff;
    fifo_head = acpc_result_type'(fifo_out_data);
    nxt_mclk_d   = mclk_s;
    nxt_cvs_d    = cvs_s;
    nxt_rd_act_d = rd_act;
    nxt_wr_act_d = wr_act;
  end

  // data pins pass two stages before the write capture reads them
  always_comb begin
    nxt_db_meta = db_in;
    nxt_db_sync = db_meta_ff;
  end

  // conversion sequencer: counts only master clock edges, so bursts work
  // the tail wait stands for the fixed delay after the last master clock edge
  // a full queue keeps busy high: the result waits rather than being dropped
  always_comb begin
    nxt_state    = state_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_tail_cnt = tail_cnt_ff;
    nxt_hold     = hold_ff;
    nxt_busy     = busy_ff;
    sar_start    = 1'b0;
    fifo_in_valid = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (cvs_fall && pwr_ff) begin
          nxt_state    = ST_CONV;
          nxt_hold     = 1'b1;
          nxt_busy     = 1'b1;
          nxt_edge_cnt = CNT_ZERO;
          sar_start    = 1'b1;
        end
      end
      ST_CONV: begin
        if (mclk_rise) begin
          nxt_edge_cnt = edge_cnt_ff + CNT_ONE;
          if (32'(edge_cnt_ff) == CONV_EDGES - 1) begin
            nxt_hold     = 1'b0;
            nxt_state    = ST_TAIL;
            nxt_tail_cnt = CNT_ZERO;
          end
        end
      end
      ST_TAIL: begin
        nxt_tail_cnt = tail_cnt_ff + CNT_ONE;
        if (32'(tail_cnt_ff) >= TAIL_P - 1) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          nxt_state = ST_IDLE;
          nxt_busy  = 1'b0;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // host side: read pops the next result, write loads the control word
  always_comb begin
    fifo_out_ready = rd_fall && fifo_out_valid;
    nxt_out_reg    = fifo_out_ready ? fifo_head.code : out_reg_ff;
    nxt_ctrl       = wr_rise ? db_sync_ff : ctrl_ff;
  end

  // overrun flag: a refused load sets it, a read clears it
  always_comb begin
    nxt_ovr        = ovr_ff;
    if (rd_fall) begin
      nxt_ovr = 1'b0;
    end
    if (state_ff == ST_LOAD && !fifo_in_ready) begin
      nxt_ovr = 1'b1;                                        // set wins over clear
    end
  end

  // power state: auto power-down after a load, a start rise wakes the core
  // a wake rise never starts a conversion; only a later fall does
  always_comb begin
    nxt_pwr = pwr_ff;
    if (state_ff == ST_IDLE && busy_ff == 1'b0 && cvs_rise) begin
      nxt_pwr = 1'b1;
    end else if (state_ff == ST_LOAD && fifo_in_ready &&
                 (ctrl_ff[PWR_LSB +: 2] == PWR_AUTO_SHUT ||
                  ctrl_ff[PWR_LSB +: 2] == PWR_AUTO_STBY)) begin
      nxt_pwr = 1'b0;
    end
  end

  // edge detector history; reset to pin idle levels so no false edge follows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mclk_d_ff   <= 1'b0;
      cvs_d_ff    <= 1'b1;
      rd_act_d_ff <= 1'b0;
      wr_act_d_ff <= 1'b0;
    end else begin
      mclk_d_ff   <= nxt_mclk_d;
      cvs_d_ff    <= nxt_cvs_d;
      rd_act_d_ff <= nxt_rd_act_d;
      wr_act_d_ff <= nxt_wr_act_d;
    end
  end

  // data pin synchroniser stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      db_meta_ff  <= '0;
      db_sync_ff  <= '0;
    end else begin
      db_meta_ff  <= nxt_db_meta;
      db_sync_ff  <= nxt_db_sync;
    end
  end

  // sequencer state: phase, edge and tail counters, hold and busy
  // busy and hold come straight from flops, so the pins never glitch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff    <= ST_IDLE;
      edge_cnt_ff <= CNT_ZERO;
      tail_cnt_ff <= CNT_ZERO;
      hold_ff     <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      edge_cnt_ff <= nxt_edge_cnt;
      tail_cnt_ff <= nxt_tail_cnt;
      hold_ff     <= nxt_hold;
      busy_ff     <= nxt_busy;
    end
  end

  // host port state: output register and control word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_reg_ff  <= CTRL_RESET[DATA_W-1:0];
      ctrl_ff     <= CTRL_RESET[DATA_W-1:0];
    end else begin
      out_reg_ff  <= nxt_out_reg;
      ctrl_ff     <= nxt_ctrl;
    end
  end

  // sticky overrun flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ovr_ff      <= 1'b0;
    end else begin
      ovr_ff      <= nxt_ovr;
    end
  end

  // power state register; the core comes out of reset powered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_ff      <= 1'b1;
    end else begin
      pwr_ff      <= nxt_pwr;
    end
  end

  // outputs; data pins driven only during a selected read
  assign db_oe          = rd_act && rd_act_d_ff;
  assign db_out         = out_reg_ff;
  assign busy           = busy_ff;
  assign hold           = hold_ff;
  assign powered_up     = pwr_ff;
  assign ctrl_word      = ctrl_ff;
  assign ctrl_wr_pulse  = wr_rise;
  assign result_overrun = ovr_ff;
endmodule : acpc_ctrl

// file: dv/acpc_ctrl_props.sv
// checker of conversion, track-and-hold and host strobe timing
`timescale 1ns/10ps
module acpc_ctrl_chk
  import acpc_pkg::*;
#(
  parameter int TAIL_P = 5
) (
  input wire logic                      ref_clk,
  input wire logic                      rst,
  input wire acpc_pkg::acpc_strobe_type host_strobe,
  input wire logic                      db_oe,
  input wire logic                      busy,
  input wire logic                      hold,
  input wire logic                      powered_up,
  input wire logic                      sar_start,
  input wire logic                      ctrl_wr_pulse,
  input wire logic                      result_overrun
);
  import acpc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_busy_rise: assert property (sar_start |=> busy && hold)
    else $error("busy or hold missing after start");
  chk_start_idle: assert property (sar_start |-> !busy && powered_up)
    else $error("start taken while busy or down");
  chk_busy_stays: assert property (busy && hold |=> busy)
    else $error("busy fell during hold");
  chk_hold_in_busy: assert property (hold |-> busy)
    else $error("hold without busy");
  chk_tail_len: assert property ($fell(hold) |-> busy [*5])
    else $error("tail shorter than expected");
  chk_busy_fall: assert property ($fell(busy) |-> !$past(hold, TAIL_P) && $past(busy, TAIL_P))
    else $error("busy fell before tail ended");
  chk_oe_cause: assert property ($rose(db_oe) |->
      !$past(host_strobe.cs_n, 2) && !$past(host_strobe.rd_n, 2))
    else $error("data driven without cs and rd");
  chk_oe_release: assert property (host_strobe.rd_n [*5] |-> !db_oe)
    else $error("data driven with rd high");
  chk_wr_cs: assert property (ctrl_wr_pulse |-> !$past(host_strobe.cs_n, 2))
    else $error("write taken without cs");
  cov_start: cover property (sar_start);
  cov_done: cover property ($fell(busy));
  cov_read: cover property ($rose(db_oe));
  cov_ovr: cover property ($rose(result_overrun));
endmodule : acpc_ctrl_chk
bind acpc_ctrl acpc_ctrl_chk #(.TAIL_P(TAIL_P)) chk_u (.ref_clk(ref_clk), .rst(rst),
  .host_strobe(host_strobe), .db_oe(db_oe), .busy(busy), .hold(hold),
  .powered_up(powered_up), .sar_start(sar_start), .ctrl_wr_pulse(ctrl_wr_pulse),
  .result_overrun(result_overrun));

// file: dv/acpc_host_model.sv
// host processor model: master clock bursts and parallel strobes
`timescale 1ns/10ps
module acpc_host_model
  import acpc_pkg::*;
(
  input  wire logic                    ref_clk,
  output logic                         master_clock_in,
  output acpc_pkg::acpc_strobe_type    host_strobe,
  output logic [acpc_pkg::DATA_W-1:0]  db_in,
  input  wire logic [acpc_pkg::DATA_W-1:0] db_out,
  input  wire logic                    db_oe,
  output logic [acpc_pkg::DATA_W-1:0]  q,
  output logic                         oe_seen
);
  import acpc_pkg::*;
  initial begin
    master_clock_in = 1'b0;
    host_strobe = 3'h7;
    db_in = 12'h5A5;
    q = 12'h000;
    oe_seen = 1'b0;
  end
  // burst of rising edges, clock stands low between bursts
  task automatic mclk(input int n, input int half);
    repeat (n) begin
      repeat (half) @(negedge ref_clk);
      master_clock_in = 1'b1;
      repeat (half) @(negedge ref_clk);
      master_clock_in = 1'b0;
    end
  endtask : mclk
  // one strobe cycle framed by chip select, bus sampled while strobe is low
  task automatic access(input logic cs_n, input logic wr, input logic [11:0] d);
    @(negedge ref_clk);
    host_strobe.cs_n = cs_n;
    db_in = d;
    repeat (2) @(negedge ref_clk);
    if (wr) host_strobe.wr_n = 1'b0;
    else host_strobe.rd_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    q = db_out;
    oe_seen = db_oe;
    host_strobe.wr_n = 1'b1;
    host_strobe.rd_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    host_strobe.cs_n = 1'b1;
    db_in = ~d; // released bus no longer shows the data
  endtask : access
endmodule : acpc_host_model

// file: dv/testbench.sv
// self-checking testbench of conversion control and host port
`timescale 1ns/10ps
module testbench;
  import acpc_pkg::*;
  logic            ref_clk, rst, conv_n, db_oe, busy, hold, pwr, start, wr_p, ovr, mclk, oe_seen;
  acpc_strobe_type strb;
  acpc_result_type res;
  logic [11:0]     db_in, db_out, ctrl, q;
  int              error_cnt, check_count, cyc;
  acpc_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .master_clock_in(mclk),
    .conversion_start_n(conv_n), .host_strobe(strb), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe), .busy(busy), .hold(hold), .powered_up(pwr), .sar_start(start),
    .sar_result(res), .ctrl_word(ctrl), .ctrl_wr_pulse(wr_p), .result_overrun(ovr));
  acpc_host_model host_u (.ref_clk(ref_clk), .master_clock_in(mclk), .host_strobe(strb),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .q(q), .oe_seen(oe_seen));
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk_bit(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word
  // one conversion; pd expects power-down after load, full expects a refused load
  task automatic t_conv(input logic [11:0] code, input int half, input logic pd,
                        input logic full);
    int n = 0;
    res = {3'h5, code};
    @(negedge ref_clk);
    chk_bit(busy, 1'b0, "idle before start");
    conv_n = 1'b0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(busy, 1'b1, "busy");
    chk_bit(hold, 1'b1, "hold");
    host_u.mclk(12, half);
    repeat (4) @(negedge ref_clk);
    chk_bit(hold, 1'b1, "hold at 12");
    host_u.mclk(1, 2);
    repeat (2) @(negedge ref_clk);
    chk_bit(hold, 1'b0, "track");
    chk_bit(busy, 1'b1, "tail");
    n = 0;
    while (busy !== 1'b0 && n < 12) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit(busy, full, "load");
    if (full) begin
      chk_bit(ovr, 1'b1, "overrun");
      return;
    end
    chk_word(12'(n), 12'(TAIL_CYCLES), "tail length");
    repeat (3) @(negedge ref_clk);
    chk_bit(pwr, ~pd, "power after load");
    conv_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk_bit(pwr, 1'b1, "power up");
  endtask : t_conv
  task automatic t_read(input logic [11:0] exp);
    host_u.access(1'b0, 1'b0, 12'h000);
    chk_bit(oe_seen, 1'b1, "oe");
    chk_word(q, exp, "result");
  endtask : t_read
  task automatic t_write(input logic [11:0] v);
    host_u.access(1'b0, 1'b1, v);
    chk_word(ctrl, v, "ctrl");
  endtask : t_write
  task automatic t_nocs;
    host_u.access(1'b1, 1'b0, 12'h000);
    chk_bit(oe_seen, 1'b0, "read without cs");
    host_u.access(1'b1, 1'b1, 12'h0A5);
    chk_word(ctrl, 12'h000, "write without cs");
  endtask : t_nocs
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("mismatch %0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    conv_n = 1'b1;
    res = '0;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_bit(busy, 1'b0, "reset busy");
    chk_bit(db_oe, 1'b0, "reset oe");
    chk_bit(pwr, 1'b1, "reset power");
    t_nocs();
    t_conv(12'h123, 2, 1'b0, 1'b0);
    t_read(12'h123);
    t_conv(12'hABC, 5, 1'b0, 1'b0);
    t_read(12'hABC);
    t_write(12'h002);
    t_conv(12'h456, 2, 1'b1, 1'b0);
    t_read(12'h456);
    t_write(12'h001);
    t_conv(12'h789, 3, 1'b1, 1'b0);
    t_read(12'h789);
    t_write(12'h000);
    for (int i = 0; i < 4; i++) t_conv(12'h800 + 12'(i), 2, 1'b0, 1'b0);
    t_conv(12'hFFF, 2, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) t_read(12'h800 + 12'(i));
    t_read(12'hFFF);
    chk_bit(busy, 1'b0, "drained");
    conv_n = 1'b1;
    stop_test();
  end
endmodule : testbench
